// >>> pwdt_regs.svh
/*
 * Constants of the program watchdog timer: counter reload values, prescaler
 * limits, refresh key bytes, option bit positions and start-up settling.
 * Assumes it is included by bare name after `default_nettype none.
 */
`ifndef PWDT_REGS_SVH
`define PWDT_REGS_SVH

// ==========================================================================
// counter
`define PWDT_FULL_COUNT 15'h7fff
`define PWDT_PROT_COUNT 15'h0fff
`define PWDT_ZERO_COUNT 15'h0000
`define PWDT_COUNT_STEP 15'h0001

// ==========================================================================
// prescaler, last count of each ratio (ratio minus one)
`define PWDT_DIV16_LAST 7'h0f
`define PWDT_DIV128_LAST 7'h7f
`define PWDT_PRESC_STEP 7'h01

// ==========================================================================
// refresh key bytes
`define PWDT_REFRESH_FIRST 8'h00
`define PWDT_REFRESH_SECOND 8'hff

// ==========================================================================
// nonvolatile option location bit positions
`define PWDT_OPT_START_BIT 0
`define PWDT_OPT_PROT_BIT 7

// ==========================================================================
// option sampling after reset release
`define PWDT_OPT_SETTLE 2'h2
`define PWDT_SETTLE_STEP 2'h1

`endif

// >>> pwdt_pkg.sv
/*
 * Types of the program watchdog timer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pwdt_pkg;

    // ======================================================================
    // control states of the counter
    typedef enum logic [1:0] {
        PWDT_ST_LOAD,
        PWDT_ST_STOP,
        PWDT_ST_RUN
    } pwdt_state_type;

endpackage

// >>> pwdt_prescaler.sv
/*
 * Divide-by-16 or divide-by-128 prescaler of the watchdog count source.
 * Assumes run and div_sel come from logic on mclk; cleared only by rst.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pwdt_regs.svh"

module pwdt_prescaler
    import pwdt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic div_sel,
    output logic tick
);

    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic [6:0] last;

    // ======================================================================
    // divider
    always_comb begin
        last = div_sel ? `PWDT_DIV128_LAST : `PWDT_DIV16_LAST;
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (run) begin
            // a ratio change mid-count finishes within one wrap
            if (cnt_q == last) begin
                cnt_d = 7'h00;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + `PWDT_PRESC_STEP;
            end
        end
    end

    // no refresh input here: the prescaler keeps its phase across refreshes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 7'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

    // ======================================================================
    // checks
    chk_presc_halt: assert property (@(posedge mclk) disable iff (rst)
        !run |=> !tick)
        else $error("prescaler ticked while halted");

    chk_presc_ratio: assert property (@(posedge mclk) disable iff (rst)
        (run && !div_sel && cnt_q == `PWDT_DIV16_LAST) |=> tick)
        else $error("divide by 16 tick missing");

endmodule
`default_nettype wire

// >>> pwdt_top.sv
/*
 * Program watchdog timer: 15-bit down-counter, refresh key sequence,
 * start option, count source protection mode and underflow action.
 * Assumes register writes arrive as one-cycle strobes on mclk; option_byte
 * and lso_clk come from outside the clock domain and are synchronised here.
 */
// Notes on behaviour
// - 15-bit counter decrements once per tick.
// - source is cpu clock, or slow oscillator.
// - prescaler divides by 16 or 128.
// - full count underflows after ratio*32768 clocks.
// - reload only after 00h then FFh.
// - prescaler cleared only by system reset.
// - start option holds counter until start write.
// - start option bit 0, program cannot write.
// - unprotected counter freezes in stop, wait, hold.
// - action bit picks interrupt or reset.
// - protected underflow always gives reset.
// - protection from option bit or software.
// - protected counter never freezes, stop refused.
// - protection entry loads 0FFFh, forces oscillator, reset.
// - protected mode ignores stop and oscillator writes.
// - option bit 7; protection sticky once on.
`timescale 1ns/100ps
`default_nettype none
`include "pwdt_regs.svh"

module pwdt_top
    import pwdt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic refresh_wr,
    input wire logic [7:0] refresh_data,
    input wire logic start_wr,
    input wire logic prescale_select_bit,
    input wire logic action_wr,
    input wire logic action_data,
    input wire logic protect_wr,
    input wire logic protect_data,
    input wire logic clk_ctrl_wr,
    input wire logic clk_ctrl_stop_data,
    input wire logic clk_ctrl_lso_stop_data,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic bus_hold,
    input wire logic lso_clk,
    input wire logic [7:0] option_byte,
    output logic [14:0] count_value,
    output logic counting,
    output logic protect_enable,
    output logic underflow_action_bit,
    output logic stop_mode_entry_bit,
    output logic low_speed_osc_stop_bit,
    output logic wdt_irq,
    output logic wdt_reset
);

    // ======================================================================
    // state
    pwdt_state_type st_q, st_d;
    logic [14:0] counter_q, counter_d;
    logic [1:0] settle_q, settle_d;
    logic [1:0] opt_meta_q, opt_meta_d;
    logic [1:0] opt_sync_q, opt_sync_d;
    logic start_opt_q, start_opt_d;
    logic prot_q, prot_d;
    logic armed_q, armed_d;
    logic action_q, action_d;
    logic stop_bit_q, stop_bit_d;
    logic lso_stop_q, lso_stop_d;
    logic lso_meta_q, lso_meta_d;
    logic lso_sync_q, lso_sync_d;
    logic lso_prev_q, lso_prev_d;
    logic irq_q, irq_d;
    logic wreset_q, wreset_d;
    logic run_q, run_d;

    logic presc_tick;
    logic presc_run;
    logic lso_rise;
    logic tick_src;
    logic freeze;
    logic refresh_ok;
    logic underflow;
    logic prot_set;
    logic [14:0] full_val;

    // ======================================================================
    // prescaler
    // only runs on the cpu clock path; the slow oscillator needs no divider
    assign presc_run = (st_q == PWDT_ST_RUN) && !freeze && !prot_q;

    pwdt_prescaler u_presc (
        .mclk(mclk),
        .rst(rst),
        .run(presc_run),
        .div_sel(prescale_select_bit),
        .tick(presc_tick)
    );

    // ======================================================================
    // next state
    always_comb begin
        st_d = st_q;
        counter_d = counter_q;
        settle_d = settle_q;
        start_opt_d = start_opt_q;
        prot_d = prot_q;
        armed_d = armed_q;
        action_d = action_q;
        stop_bit_d = stop_bit_q;
        lso_stop_d = lso_stop_q;
        irq_d = 1'b0;
        wreset_d = 1'b0;
        underflow = 1'b0;
        refresh_ok = 1'b0;

        opt_meta_d = {option_byte[`PWDT_OPT_PROT_BIT], option_byte[`PWDT_OPT_START_BIT]};
        opt_sync_d = opt_meta_q;
        lso_meta_d = lso_clk;
        lso_sync_d = lso_meta_q;
        lso_prev_d = lso_sync_q;

        lso_rise = lso_sync_q && !lso_prev_q;
        tick_src = prot_q ? lso_rise : presc_tick;
        freeze = !prot_q && (stop_mode || wait_mode || bus_hold);
        full_val = prot_q ? `PWDT_PROT_COUNT : `PWDT_FULL_COUNT;
        prot_set = protect_wr && protect_data && !prot_q && (st_q != PWDT_ST_LOAD);

        // key sequence: any other byte disarms, 00h re-arms
        if (refresh_wr && st_q != PWDT_ST_LOAD) begin
            armed_d = (refresh_data == `PWDT_REFRESH_FIRST);
            refresh_ok = armed_q && (refresh_data == `PWDT_REFRESH_SECOND);
        end

        case (st_q)
            PWDT_ST_LOAD: begin
                // option bits read only once, never written by program
                settle_d = settle_q + `PWDT_SETTLE_STEP;
                if (settle_q == `PWDT_OPT_SETTLE) begin
                    settle_d = settle_q;
                    start_opt_d = opt_sync_q[0];
                    if (!opt_sync_q[1]) begin
                        prot_d = 1'b1;
                        counter_d = `PWDT_PROT_COUNT;
                        action_d = 1'b1;
                        lso_stop_d = 1'b0;
                    end
                    st_d = opt_sync_q[0] ? PWDT_ST_STOP : PWDT_ST_RUN;
                end
            end
            PWDT_ST_STOP: begin
                if (refresh_ok) begin
                    counter_d = full_val;
                end
                if (start_wr) begin
                    st_d = PWDT_ST_RUN;
                    counter_d = full_val;
                end
            end
            PWDT_ST_RUN: begin
                if (refresh_ok) begin
                    counter_d = full_val;
                end else if (tick_src && !freeze) begin
                    if (counter_q == `PWDT_ZERO_COUNT) begin
                        underflow = 1'b1;
                        counter_d = full_val;
                    end else begin
                        counter_d = counter_q - `PWDT_COUNT_STEP;
                    end
                end
            end
            default: begin
                st_d = PWDT_ST_LOAD;
            end
        endcase

        irq_d = underflow && !prot_q && !action_q;
        wreset_d = underflow && (prot_q || action_q);

        if (action_wr && !prot_q) begin
            action_d = action_data;
        end
        // writes are dropped in protection mode, so the stop bit keeps the value it had at entry
        if (clk_ctrl_wr && !prot_q) begin
            stop_bit_d = clk_ctrl_stop_data;
            lso_stop_d = clk_ctrl_lso_stop_data;
        end

        // entry values win over refresh, underflow reload and action or oscillator-stop writes; a same-cycle stop bit write still lands
        if (prot_set) begin
            prot_d = 1'b1;
            counter_d = `PWDT_PROT_COUNT;
            action_d = 1'b1;
            lso_stop_d = 1'b0;
        end

        run_d = (st_d == PWDT_ST_RUN);
    end

    // ======================================================================
    // registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q <= PWDT_ST_LOAD;
            counter_q <= `PWDT_FULL_COUNT;
            settle_q <= 2'h0;
            opt_meta_q <= 2'h3;
            opt_sync_q <= 2'h3;
            start_opt_q <= 1'b1;
            prot_q <= 1'b0;
            armed_q <= 1'b0;
            action_q <= 1'b0;
            stop_bit_q <= 1'b0;
            lso_stop_q <= 1'b0;
            lso_meta_q <= 1'b0;
            lso_sync_q <= 1'b0;
            lso_prev_q <= 1'b0;
            irq_q <= 1'b0;
            wreset_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            st_q <= st_d;
            counter_q <= counter_d;
            settle_q <= settle_d;
            opt_meta_q <= opt_meta_d;
            opt_sync_q <= opt_sync_d;
            start_opt_q <= start_opt_d;
            prot_q <= prot_d;
            armed_q <= armed_d;
            action_q <= action_d;
            stop_bit_q <= stop_bit_d;
            lso_stop_q <= lso_stop_d;
            lso_meta_q <= lso_meta_d;
            lso_sync_q <= lso_sync_d;
            lso_prev_q <= lso_prev_d;
            irq_q <= irq_d;
            wreset_q <= wreset_d;
            run_q <= run_d;
        end
    end

    assign count_value = counter_q;
    assign counting = run_q;
    assign protect_enable = prot_q;
    assign underflow_action_bit = action_q;
    assign stop_mode_entry_bit = stop_bit_q;
    assign low_speed_osc_stop_bit = lso_stop_q;
    assign wdt_irq = irq_q;
    assign wdt_reset = wreset_q;

    // ======================================================================
    // checks
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    chk_count_decrement: assert property (
        (st_q == PWDT_ST_RUN && tick_src && !freeze && counter_q != `PWDT_ZERO_COUNT
            && !refresh_ok && !prot_set)
        |=> counter_q == $past(counter_q) - `PWDT_COUNT_STEP)
        else $error("counter did not step down on a tick");

    chk_slow_source: assert property (
        (prot_q && st_q == PWDT_ST_RUN && !lso_rise && !refresh_ok) |=> $stable(counter_q))
        else $error("protected counter moved without oscillator edge");

    chk_refresh_reload: assert property (
        (st_q == PWDT_ST_RUN && refresh_wr && refresh_data == `PWDT_REFRESH_SECOND
            && armed_q && !prot_set)
        |=> counter_q == $past(full_val))
        else $error("key sequence did not reload counter");

    chk_refresh_single: assert property (
        (st_q == PWDT_ST_RUN && refresh_wr && !armed_q && !tick_src && !prot_set)
        |=> $stable(counter_q))
        else $error("unarmed refresh changed counter");

    chk_start_hold: assert property (
        (st_q == PWDT_ST_STOP && !start_wr) |=> st_q == PWDT_ST_STOP)
        else $error("counter started without start write");

    chk_option_fixed: assert property (
        (st_q != PWDT_ST_LOAD) |=> $stable(start_opt_q))
        else $error("start option changed after load");

    chk_freeze_hold: assert property (
        (st_q == PWDT_ST_RUN && freeze && !refresh_ok && !prot_set)
        |=> $stable(counter_q))
        else $error("counter moved while frozen");

    chk_irq_action: assert property (
        (underflow && !prot_q && !action_q) |=> (wdt_irq && !wdt_reset))
        else $error("underflow did not raise interrupt");

    chk_prot_reset: assert property (
        (underflow && prot_q) |=> (wdt_reset && !wdt_irq))
        else $error("protected underflow did not reset");

    chk_prot_sticky: assert property (
        prot_q |=> prot_q)
        else $error("protection mode dropped");

    chk_prot_entry: assert property (
        $rose(prot_q) |-> (counter_q == `PWDT_PROT_COUNT && action_q && !lso_stop_q))
        else $error("protection entry values wrong");

    chk_clk_ctrl_locked: assert property (
        (prot_q && clk_ctrl_wr) |=> ($stable(stop_bit_q) && $stable(lso_stop_q)))
        else $error("clock control write accepted while protected");

    chk_prot_nofreeze: assert property (
        (prot_q && st_q == PWDT_ST_RUN && lso_rise && !refresh_ok
            && counter_q != `PWDT_ZERO_COUNT) |=> counter_q != $past(counter_q))
        else $error("protected counter froze");

    cov_irq: cover property (wdt_irq);
    cov_reset: cover property (wdt_reset && prot_q);
    cov_refresh: cover property (refresh_ok && st_q == PWDT_ST_RUN);
    cov_prot_sw: cover property (prot_set);

endmodule
`default_nettype wire

// >>> tb_top.sv
/*
 * Self-checking testbench of the program watchdog timer top level.
 * Assumes pwdt_top and its prescaler are compiled first; the slow
 * oscillator is modelled as a free-running clock of 9 mclk periods.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pwdt_regs.svh"

module tb_top;

    // ======================================================================
    // signals
    localparam int LSO_PER = 9;
    localparam int LIMIT = 60000;
    logic mclk, rst, refresh_wr, start_wr, sel, act_wr, act_d, protect_wr, protect_d;
    logic cc_wr, cc_stop, cc_lso, stop_mode, wait_mode, bus_hold, lso_clk;
    logic [7:0] refresh_data, option_byte;
    logic [14:0] count_value, v;
    logic counting, protect_enable, action, stop_bit, lso_bit, wdt_irq, wdt_reset, irq_seen;
    int miscompares, n_tests, n;
    int cyc = 0;
    logic [7:0] opts [3] = '{8'h00, 8'h01, 8'h80};

    pwdt_top pwdt_top_i (
        .mclk(mclk), .rst(rst), .refresh_wr(refresh_wr), .refresh_data(refresh_data),
        .start_wr(start_wr), .prescale_select_bit(sel), .action_wr(act_wr),
        .action_data(act_d), .protect_wr(protect_wr), .protect_data(protect_d),
        .clk_ctrl_wr(cc_wr), .clk_ctrl_stop_data(cc_stop), .clk_ctrl_lso_stop_data(cc_lso),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .bus_hold(bus_hold),
        .lso_clk(lso_clk), .option_byte(option_byte), .count_value(count_value),
        .counting(counting), .protect_enable(protect_enable),
        .underflow_action_bit(action), .stop_mode_entry_bit(stop_bit),
        .low_speed_osc_stop_bit(lso_bit), .wdt_irq(wdt_irq), .wdt_reset(wdt_reset)
    );

    // ======================================================================
    // clocks and watchdog of the run
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // odd phase offset keeps the slow clock edges off the mclk edges
    initial begin
        lso_clk = 1'b0;
        #3;
        forever #36 lso_clk = ~lso_clk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (wdt_irq === 1'b1) begin
            irq_seen <= 1'b1;
        end
        if (cyc == LIMIT) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    // ======================================================================
    // tasks
    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle strobe: 0 refresh, 1 start, 2 action, 3 protect, 4 clock bits
    task automatic wr(input int which, input logic [7:0] d);
        @(posedge mclk);
        case (which)
            0: begin
                refresh_wr <= 1'b1;
                refresh_data <= d;
            end
            1: start_wr <= 1'b1;
            2: begin
                act_wr <= 1'b1;
                act_d <= d[0];
            end
            3: begin
                protect_wr <= 1'b1;
                protect_d <= d[0];
            end
            default: begin
                cc_wr <= 1'b1;
                cc_stop <= d[0];
                cc_lso <= d[1];
            end
        endcase
        @(posedge mclk);
        {refresh_wr, start_wr, act_wr, protect_wr, cc_wr} <= 5'h00;
        #1;
    endtask

    task automatic hold(input int i, input logic val);
        @(posedge mclk);
        case (i)
            0: stop_mode <= val;
            1: wait_mode <= val;
            default: bus_hold <= val;
        endcase
        #1;
    endtask

    task automatic wait_change();
        logic [14:0] p;
        int k;
        p = count_value;
        k = 0;
        while (count_value === p && k < 400) begin
            @(posedge mclk);
            #1;
            k++;
        end
        check({14'h0, k < 400}, 15'h1);
    endtask

    task automatic reset_dut(input logic [7:0] opt);
        @(posedge mclk);
        rst <= 1'b1;
        option_byte <= opt;
        repeat (3) @(posedge mclk);
        #1;
        check(count_value, `PWDT_FULL_COUNT);
        check({8'h00, counting, protect_enable, action, stop_bit, lso_bit, wdt_irq, wdt_reset}, 15'h0);
        @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        check({14'h0, counting}, {14'h0, ~opt[0]});
        check({14'h0, protect_enable}, {14'h0, ~opt[7]});
    endtask

    // ======================================================================
    // main sequence
    initial begin
        {rst, refresh_wr, start_wr, sel, act_wr, act_d, protect_wr, protect_d} = 8'h80;
        {cc_wr, cc_stop, cc_lso, stop_mode, wait_mode, bus_hold} = 6'h00;
        refresh_data = 8'h00;
        option_byte = 8'h81;
        miscompares = 0;
        n_tests = 0;
        irq_seen = 1'b0;
        reset_dut(8'h81);
        // a refresh while stopped must not start the count
        wr(0, 8'h00);
        wr(0, 8'hff);
        @(posedge mclk);
        #1;
        check({14'h0, counting}, 15'h0);
        wr(1, 8'h00);
        @(posedge mclk);
        #1;
        check(count_value, `PWDT_FULL_COUNT);
        check({14'h0, counting}, 15'h1);
        wait_change();
        v = count_value;
        repeat (64) @(posedge mclk);
        #1;
        check(count_value, v - 15'h4);
        // refresh mid-period keeps the prescaler phase
        wait_change();
        wr(0, 8'h00);
        wr(0, 8'hff);
        repeat (10) @(posedge mclk);
        #1;
        check(count_value, `PWDT_FULL_COUNT);
        repeat (2) @(posedge mclk);
        #1;
        check(count_value, 15'h7ffe);
        // broken key sequences
        wait_change();
        v = count_value;
        wr(0, 8'hff);
        wr(0, 8'h00);
        wr(0, 8'h55);
        wr(0, 8'hff);
        @(posedge mclk);
        #1;
        check(count_value, v);
        // divide by 128; a ratio change lets the running count go on to the new ratio's last count
        @(posedge mclk);
        sel <= 1'b1;
        wait_change();
        wait_change();
        v = count_value;
        repeat (256) @(posedge mclk);
        #1;
        check(count_value, v - 15'h2);
        @(posedge mclk);
        sel <= 1'b0;
        wait_change();
        wait_change();
        for (int i = 0; i < 3; i++) begin
            wait_change();
            v = count_value;
            hold(i, 1'b1);
            repeat (100) @(posedge mclk);
            #1;
            check(count_value, v);
            hold(i, 1'b0);
            wait_change();
            check(count_value, v - 15'h1);
        end
        wr(2, 8'h01);
        @(posedge mclk);
        #1;
        check({14'h0, action}, 15'h1);
        wr(2, 8'h00);
        wr(4, 8'h03);
        @(posedge mclk);
        #1;
        check({12'h0, action, stop_bit, lso_bit}, 15'h3);
        // protection entry and its locks
        // looked at on the entry edge: the next slow edge may already count down
        wr(3, 8'h01);
        check(count_value, `PWDT_PROT_COUNT);
        check({11'h0, protect_enable, action, stop_bit, lso_bit}, 15'he);
        wr(2, 8'h00);
        wr(4, 8'h02);
        wr(3, 8'h00);
        @(posedge mclk);
        #1;
        check({11'h0, protect_enable, action, stop_bit, lso_bit}, 15'he);
        for (int i = 0; i < 3; i++) begin
            hold(i, 1'b1);
        end
        wait_change();
        v = count_value;
        repeat (20 * LSO_PER) @(posedge mclk);
        #1;
        n = int'(v - count_value);
        check({14'h0, n >= 19 && n <= 21}, 15'h1);
        wr(0, 8'h00);
        wr(0, 8'hff);
        irq_seen = 1'b0;
        n = 0;
        while (wdt_reset !== 1'b1 && n < 40000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check({14'h0, n > 4096 * LSO_PER - 60 && n < 4096 * LSO_PER + 60}, 15'h1);
        check({14'h0, irq_seen}, 15'h0);
        @(posedge mclk);
        #1;
        check({14'h0, wdt_reset}, 15'h0);
        for (int i = 0; i < 3; i++) begin
            hold(i, 1'b0);
        end
        foreach (opts[i]) begin
            reset_dut(opts[i]);
        end
        wrap_up();
    end

endmodule

`default_nettype wire
